// file: rtl/rtc_channel_cfg.sv
// Notes on behaviour
// - Start index zero unless 0x2f bit 3 set
// - Override start index from 0x39 bits 4:0
// - Index addresses boost table from 0x40 upward
// - Swing code n gives 0.6 + 0.1n V
// - De-emphasis code 000 is 0 dB always
// - Nonzero codes map by range bit to dB
// - Shared set plus one set per channel
// - Shared setting picks targeted channel set
// - 0xff bits 1:0 pick channel when bit 2
// - Boost table 0x40-0x5f, four 2-bit stages
`default_nettype none
module rtc_channel_cfg #(
  parameter int unsigned NUM_CH = rtc_pkg::NUM_CH_DEF
) (
  input  wire logic                                 core_clk,
  input  wire logic                                 rst_b,
  input  wire logic [rtc_pkg::ADDR_W-1:0]           regAddr,
  input  wire logic [rtc_pkg::DATA_W-1:0]           regWrData,
  input  wire logic                                 regWr,
  input  wire logic                                 regRd,
  output logic      [rtc_pkg::DATA_W-1:0]           regRdData,
  output logic                                      regRdValid,
  input  wire logic [NUM_CH-1:0][rtc_pkg::IDX_W-1:0] adaptIdx,
  output logic      [NUM_CH-1:0][rtc_pkg::DATA_W-1:0] adaptBoost,
  output logic      [NUM_CH-1:0][rtc_pkg::IDX_W-1:0] adaptStartIdx,
  output logic      [NUM_CH-1:0][2:0]               vodCode,
  output logic      [NUM_CH-1:0][10:0]              vodMv,
  output logic      [NUM_CH-1:0][2:0]               demCode,
  output logic      [NUM_CH-1:0]                    demRange,
  output logic      [NUM_CH-1:0][7:0]               demTenthsDb
);
  localparam int unsigned CH_SEL_W = (NUM_CH > 1) ? $clog2(NUM_CH) : 1;
  // Output reset values derive from the control registers' reset values
  localparam logic [2:0] VOD_CODE_RST =
    rtc_pkg::SWING_RST[rtc_pkg::VOD_CODE_LSB +: rtc_pkg::VOD_CODE_W];
  localparam logic [10:0] VOD_MV_RST =
    rtc_pkg::VOD_BASE_MV + 11'(VOD_CODE_RST) * rtc_pkg::VOD_STEP_MV;
  localparam logic [2:0] DEM_CODE_RST =
    rtc_pkg::DEEMPH_RST[rtc_pkg::DEM_CODE_LSB +: rtc_pkg::DEM_CODE_W];
  localparam logic DEM_RANGE_RST =
    rtc_pkg::DEEMPH_RST[rtc_pkg::DEM_RANGE_BIT];
  localparam logic [7:0] BOOST_OUT_RST =
    rtc_pkg::BOOST_TBL_RST[rtc_pkg::DATA_W-1:0];
  localparam int unsigned DEM_RST_POS = DEM_CODE_RST * rtc_pkg::DATA_W;
  localparam logic [7:0] DEM_TENTHS_RST = DEM_RANGE_RST ?
    rtc_pkg::DEM_RANGE1_TENTHS[DEM_RST_POS +: rtc_pkg::DATA_W] :
    rtc_pkg::DEM_RANGE0_TENTHS[DEM_RST_POS +: rtc_pkg::DATA_W];

  function automatic logic [7:0] demLookup(input logic [2:0] code,
                                           input logic       range);
    logic [7:0] r1;
    logic [7:0] r0;
    r1 = rtc_pkg::DEM_RANGE1_TENTHS[code*8 +: 8];
    r0 = rtc_pkg::DEM_RANGE0_TENTHS[code*8 +: 8];
    demLookup = range ? r1 : r0;
  endfunction

  // Reset release through two flops
  logic rstSync1_reg;
  logic rstSync2_reg;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rstSync1_reg <= 1'b0;
      rstSync2_reg <= 1'b0;
    end else begin
      rstSync1_reg <= 1'b1;
      rstSync2_reg <= rstSync1_reg;
    end
  end
  wire logic rstIntB = rstSync2_reg;

  // Shared channel-select register
  logic [7:0] sharedSel_reg;
  wire logic  wrShared = regWr && (regAddr == rtc_pkg::SHARED_SEL_ADDR);
  wire logic  selEn    = sharedSel_reg[rtc_pkg::SEL_EN_BIT];
  wire logic  selBcast = sharedSel_reg[rtc_pkg::SEL_BCAST_BIT];
  wire logic [rtc_pkg::SEL_CH_W-1:0] selCh =
    sharedSel_reg[rtc_pkg::SEL_CH_LSB +: rtc_pkg::SEL_CH_W];
  wire logic [CH_SEL_W-1:0] selIdx = CH_SEL_W'(selCh);
  // Out-of-range select hits no channel unless broadcast is set
  wire logic selInRange = (32'(selCh) < NUM_CH);

  always_ff @(posedge core_clk or negedge rstIntB) begin
    if (!rstIntB) begin
      sharedSel_reg <= rtc_pkg::SHARED_RST;
    end else if (wrShared) begin
      sharedSel_reg <= regWrData;
    end
  end

  // 0xff always lands in the shared set, never a channel
  wire logic chWr = regWr && !wrShared && selEn;
  wire logic inTbl = (regAddr >= rtc_pkg::BOOST_TBL_BASE) &&
                     (regAddr <= rtc_pkg::BOOST_TBL_LAST);
  wire logic [rtc_pkg::IDX_W-1:0] tblOff =
    rtc_pkg::IDX_W'(regAddr - rtc_pkg::BOOST_TBL_BASE);
  // Address decode for the write path; all but isChRst also feed the read path
  wire logic isDem   = (regAddr == rtc_pkg::DRIVER_DEEMPH_CTRL);
  wire logic isSwing = (regAddr == rtc_pkg::DRIVER_SWING_CTRL);
  wire logic isOvr   = (regAddr == rtc_pkg::ADAPT_START_OVR_CTRL);
  wire logic isStart = (regAddr == rtc_pkg::ADAPT_START_INDEX);
  wire logic isChRst = (regAddr == rtc_pkg::CH_RESET_ADDR);

  logic [7:0] demCtrl_reg  [NUM_CH];
  logic [7:0] swingCtrl_reg[NUM_CH];
  logic [7:0] ovrCtrl_reg  [NUM_CH];
  logic [7:0] startIdx_reg [NUM_CH];
  logic [7:0] boostTbl_reg [NUM_CH][rtc_pkg::TBL_DEPTH];
  logic [NUM_CH-1:0] chHit;

  genvar c;
  generate
    for (c = 0; c < NUM_CH; c++) begin : gCh
      // Broadcast writes every channel set at once, only while bit 2 enables channel writes
      assign chHit[c] = chWr && (selBcast ||
                        (selInRange && (selIdx == CH_SEL_W'(c))));
      wire logic chRst = chHit[c] && isChRst &&
                         regWrData[rtc_pkg::CH_RESET_BIT];
      wire logic ovrEn = ovrCtrl_reg[c][rtc_pkg::OVR_EN_BIT];
      wire logic [rtc_pkg::IDX_W-1:0] startNext = ovrEn ?
        startIdx_reg[c][rtc_pkg::START_IDX_LSB +: rtc_pkg::IDX_W] :
        rtc_pkg::START_IDX_DEFAULT;
      wire logic [2:0] vodNext =
        swingCtrl_reg[c][rtc_pkg::VOD_CODE_LSB +: rtc_pkg::VOD_CODE_W];
      wire logic [2:0] demNext =
        demCtrl_reg[c][rtc_pkg::DEM_CODE_LSB +: rtc_pkg::DEM_CODE_W];
      wire logic rangeNext = demCtrl_reg[c][rtc_pkg::DEM_RANGE_BIT];
      wire logic [10:0] vodMvNext =
        rtc_pkg::VOD_BASE_MV + 11'(vodNext) * rtc_pkg::VOD_STEP_MV;

      always_ff @(posedge core_clk or negedge rstIntB) begin
        if (!rstIntB) begin
          demCtrl_reg[c]   <= rtc_pkg::DEEMPH_RST;
          swingCtrl_reg[c] <= rtc_pkg::SWING_RST;
          ovrCtrl_reg[c]   <= rtc_pkg::OVR_CTRL_RST;
          startIdx_reg[c]  <= rtc_pkg::START_IDX_RST;
        end else if (chRst) begin
          demCtrl_reg[c]   <= rtc_pkg::DEEMPH_RST;
          swingCtrl_reg[c] <= rtc_pkg::SWING_RST;
          ovrCtrl_reg[c]   <= rtc_pkg::OVR_CTRL_RST;
          startIdx_reg[c]  <= rtc_pkg::START_IDX_RST;
        end else if (chHit[c]) begin
          if (isDem)
            demCtrl_reg[c] <= regWrData;
          if (isSwing)
            swingCtrl_reg[c] <= regWrData;
          if (isOvr)
            ovrCtrl_reg[c] <= regWrData;
          if (isStart)
            startIdx_reg[c] <= regWrData;
        end
      end

      // Channel reset restores the default candidate table
      always_ff @(posedge core_clk or negedge rstIntB) begin
        if (!rstIntB) begin
          for (int i = 0; i < rtc_pkg::TBL_DEPTH; i++) begin
            boostTbl_reg[c][i] <= rtc_pkg::BOOST_TBL_RST[i*8 +: 8];
          end
        end else if (chRst) begin
          for (int i = 0; i < rtc_pkg::TBL_DEPTH; i++) begin
            boostTbl_reg[c][i] <= rtc_pkg::BOOST_TBL_RST[i*8 +: 8];
          end
        end else if (chHit[c] && inTbl) begin
          boostTbl_reg[c][tblOff] <= regWrData;
        end
      end

      // Registered outputs; adaptation sees new table next cycle
      always_ff @(posedge core_clk or negedge rstIntB) begin
        if (!rstIntB) begin
          adaptBoost[c]    <= BOOST_OUT_RST;
          adaptStartIdx[c] <= rtc_pkg::START_IDX_DEFAULT;
          vodCode[c]       <= VOD_CODE_RST;
          vodMv[c]         <= VOD_MV_RST;
          demCode[c]       <= DEM_CODE_RST;
          demRange[c]      <= DEM_RANGE_RST;
          demTenthsDb[c]   <= DEM_TENTHS_RST;
        end else begin
          adaptBoost[c]    <= boostTbl_reg[c][adaptIdx[c]];
          adaptStartIdx[c] <= startNext;
          vodCode[c]       <= vodNext;
          vodMv[c]         <= vodMvNext;
          demCode[c]       <= demNext;
          demRange[c]      <= rangeNext;
          demTenthsDb[c]   <= demLookup(demNext, rangeNext);
        end
      end
    end
  endgenerate

  // Read path: one cycle latency, unmapped reads return zero
  logic [7:0] chRdData;
  always_comb begin
    chRdData = 8'h00;
    if (isDem)
      chRdData = demCtrl_reg[selIdx];
    else if (isSwing)
      chRdData = swingCtrl_reg[selIdx];
    else if (isOvr)
      chRdData = ovrCtrl_reg[selIdx];
    else if (isStart)
      chRdData = startIdx_reg[selIdx];
    else if (inTbl)
      chRdData = boostTbl_reg[selIdx][tblOff];
  end

  wire logic [7:0] rdNext =
    (regAddr == rtc_pkg::SHARED_SEL_ADDR) ? sharedSel_reg :
    (selEn && selInRange) ? chRdData : 8'h00;

  always_ff @(posedge core_clk or negedge rstIntB) begin
    if (!rstIntB) begin
      regRdData  <= 8'h00;
      regRdValid <= 1'b0;
    end else begin
      regRdValid <= regRd;
      if (regRd)
        regRdData <= rdNext;
    end
  end
endmodule
`default_nettype wire

// file: rtl/rtc_pkg.sv
`default_nettype none
package rtc_pkg;
  localparam int unsigned NUM_CH_DEF = 4;
  localparam int unsigned ADDR_W     = 8;
  localparam int unsigned DATA_W     = 8;
  localparam int unsigned IDX_W      = 5;
  localparam int unsigned TBL_DEPTH  = 32;

  // Shared register (always reachable)
  localparam logic [7:0] SHARED_SEL_ADDR = 8'hff;
  localparam int unsigned SEL_CH_LSB     = 0;
  localparam int unsigned SEL_CH_W       = 2;
  localparam int unsigned SEL_EN_BIT     = 2;
  localparam int unsigned SEL_BCAST_BIT  = 3;

  // Channel registers
  localparam logic [7:0] CH_RESET_ADDR          = 8'h00;
  localparam int unsigned CH_RESET_BIT          = 2;
  localparam logic [7:0] DRIVER_DEEMPH_CTRL     = 8'h15;
  localparam logic [7:0] DRIVER_SWING_CTRL      = 8'h2d;
  localparam logic [7:0] ADAPT_START_OVR_CTRL   = 8'h2f;
  localparam logic [7:0] ADAPT_START_INDEX      = 8'h39;
  localparam logic [7:0] BOOST_TBL_BASE         = 8'h40;
  localparam logic [7:0] BOOST_TBL_LAST         = 8'h5f;

  localparam int unsigned DEM_CODE_LSB  = 0;
  localparam int unsigned DEM_CODE_W    = 3;
  localparam int unsigned DEM_RANGE_BIT = 6;
  localparam int unsigned VOD_CODE_LSB  = 0;
  localparam int unsigned VOD_CODE_W    = 3;
  localparam int unsigned OVR_EN_BIT    = 3;
  localparam int unsigned START_IDX_LSB = 0;

  // Reset values of the four channel control registers and the shared select register
  localparam logic [7:0] DEEMPH_RST    = 8'h00;
  localparam logic [7:0] SWING_RST     = 8'h00;
  localparam logic [7:0] OVR_CTRL_RST  = 8'h00;
  localparam logic [7:0] START_IDX_RST = 8'h00;
  localparam logic [7:0] SHARED_RST    = 8'h00;
  localparam logic [IDX_W-1:0] START_IDX_DEFAULT = 5'h00;

  // Default boost table, index 0 in the low byte
  localparam logic [255:0] BOOST_TBL_RST = {
    8'ha5, 8'h96, 8'h99, 8'hd5, 8'h75, 8'h69, 8'h5d, 8'h57,
    8'hc8, 8'hb0, 8'h8c, 8'h52, 8'h46, 8'ha0, 8'h82, 8'h88,
    8'h90, 8'h60, 8'hc0, 8'h50, 8'h41, 8'h30, 8'h0c, 8'h03,
    8'h80, 8'h02, 8'h08, 8'h40, 8'h10, 8'h04, 8'h01, 8'h00};

  // Swing in mV: base plus step per code
  localparam logic [10:0] VOD_BASE_MV = 11'h258;
  localparam logic [10:0] VOD_STEP_MV = 11'h064;

  // De-emphasis magnitude in tenths of dB, code 0 in the low byte
  localparam logic [63:0] DEM_RANGE1_TENTHS = {
    8'h5a, 8'h3c, 8'h32, 8'h27, 8'h21, 8'h14, 8'h09, 8'h00};
  localparam logic [63:0] DEM_RANGE0_TENTHS = {
    8'h78, 8'h4b, 8'h38, 8'h2d, 8'h23, 8'h1c, 8'h0f, 8'h00};
endpackage
`default_nettype wire

// file: dv/rtc_cfg_properties.sv
`default_nettype none
module rtc_cfg_properties #(
  parameter int unsigned NUM_CH = 4
) (
  input wire logic                    core_clk,
  input wire logic                    rst_b,
  input wire logic [7:0]              regAddr,
  input wire logic [7:0]              regWrData,
  input wire logic                    regWr,
  input wire logic                    regRd,
  input wire logic [7:0]              regRdData,
  input wire logic                    regRdValid,
  input wire logic [NUM_CH-1:0][4:0]  adaptStartIdx,
  input wire logic [NUM_CH-1:0][2:0]  vodCode,
  input wire logic [NUM_CH-1:0][10:0] vodMv,
  input wire logic [NUM_CH-1:0][2:0]  demCode,
  input wire logic [NUM_CH-1:0]       demRange,
  input wire logic [NUM_CH-1:0][7:0]  demTenthsDb
);
  logic [7:0] selReg;
  logic [1:0] ch;
  logic       chWr;
  // Shadow of the select register, so channel targets are known here
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) selReg <= 8'h00;
    else if (regWr && regAddr == 8'hff) selReg <= regWrData;
  end
  assign ch = selReg[1:0];
  assign chWr = regWr && selReg[2] && regAddr != 8'hff;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  AST_VOD_MV: assert property (
    vodMv[ch] == 11'h258 + 11'h064 * vodCode[ch])
    else $error("swing level does not match code");
  AST_DEM_ZERO: assert property (
    demCode[ch] == 3'h0 |-> demTenthsDb[ch] == 8'h00)
    else $error("code zero gives nonzero de-emphasis");
  AST_DEM_MAP: assert property (
    demTenthsDb[ch] == (demRange[ch] ?
      rtc_pkg::DEM_RANGE1_TENTHS[demCode[ch]*8 +: 8] :
      rtc_pkg::DEM_RANGE0_TENTHS[demCode[ch]*8 +: 8]))
    else $error("de-emphasis level does not match code");
  AST_START_DEF: assert property (
    chWr && regAddr == 8'h2f && !regWrData[3]
    |=> ##1 adaptStartIdx[$past(ch, 2)] == 5'h00)
    else $error("start index not zero without override");
  AST_VOD_FOLLOW: assert property (
    chWr && regAddr == 8'h2d
    |=> ##1 vodCode[$past(ch, 2)] == $past(regWrData[2:0], 2))
    else $error("swing code not taken by selected channel");
  AST_RD_VALID: assert property (
    regRdValid == $past(regRd))
    else $error("read valid does not follow the read strobe");
  AST_RD_REFUSED: assert property (
    regRd && !selReg[2] && regAddr != 8'hff |=> regRdData == 8'h00)
    else $error("unselected channel read not zero");
  AST_WR_REFUSED: assert property (
    regWr && !selReg[2] && regAddr == 8'h2d
    |=> ##1 vodCode == $past(vodCode, 2))
    else $error("unselected channel write took effect");
  AST_HOLD: assert property (
    !regWr && !$past(regWr) |=> $stable(vodCode) && $stable(demCode)
    && $stable(demRange) && $stable(adaptStartIdx))
    else $error("channel field changed without a write");
  cover property (chWr && regAddr == 8'h2d);
  cover property (regRdValid && regRdData != 8'h00);
  cover property (demCode[ch] == 3'h7 && !demRange[ch]);
  cover property (regWr && regAddr == 8'hff && regWrData[3:2] == 2'h3);
endmodule
bind rtc_channel_cfg rtc_cfg_properties #(.NUM_CH(NUM_CH)) prop_u (
  .core_clk, .rst_b, .regAddr, .regWrData, .regWr, .regRd, .regRdData,
  .regRdValid, .adaptStartIdx, .vodCode, .vodMv, .demCode, .demRange,
  .demTenthsDb);
`default_nettype wire

// file: dv/rtc_host_model.sv
`default_nettype none
module rtc_host_model (
  input  wire logic       core_clk,
  input  wire logic [7:0] regRdData,
  output var  logic [7:0] regAddr,
  output var  logic [7:0] regWrData,
  output var  logic       regWr,
  output var  logic       regRd
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    regAddr = 8'h00;
    regWrData = 8'h00;
    regWr = 1'b0;
    regRd = 1'b0;
  end
  // Callers pass documented addresses; the unmapped 0x10 goes only to rd
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    #1;
    regAddr = a;
    regWrData = d;
    regWr = 1'b1;
    @(posedge core_clk);
    #1;
    regWr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    #1;
    regAddr = a;
    regRd = 1'b1;
    @(posedge core_clk);
    #1;
    regRd = 1'b0;
    d = regRdData;
  endtask
  task automatic rmw(input logic [7:0] a, m, v);
    logic [7:0] d;
    rd(a, d);
    wr(a, (d & ~m) | (v & m));
  endtask
endmodule
`default_nettype wire

// file: dv/retimer_channel_output_config_tb.sv
`default_nettype none
module retimer_channel_output_config_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic             core_clk = 1'b0;
  logic             rst_b = 1'b0;
  logic [7:0]       regAddr, regWrData, regRdData;
  logic             regWr, regRd, regRdValid;
  logic [3:0][4:0]  adaptIdx = '0, adaptStartIdx;
  logic [3:0][7:0]  adaptBoost, demTenthsDb;
  logic [3:0][2:0]  vodCode, demCode;
  logic [3:0][10:0] vodMv;
  logic [3:0]       demRange;
  logic [7:0]       expQ[$];
  logic [7:0]       tenths[2][8] = '{'{0, 15, 28, 35, 45, 56, 75, 120},
                                     '{0, 9, 20, 33, 39, 50, 60, 90}};
  logic [31:0]      seed = 32'hde896a7b;
  int               errors = 0, numChecks = 0;
  always #2 core_clk = ~core_clk;
  rtc_channel_cfg #(.NUM_CH(4)) dut_u (.core_clk, .rst_b, .regAddr,
    .regWrData, .regWr, .regRd, .regRdData, .regRdValid, .adaptIdx,
    .adaptBoost, .adaptStartIdx, .vodCode, .vodMv, .demCode, .demRange,
    .demTenthsDb);
  rtc_host_model host_u (.core_clk, .regRdData, .regAddr, .regWrData,
    .regWr, .regRd);
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  task automatic check(input logic [10:0] got, exp);
    numChecks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [7:0] a, e);
    logic [7:0] d;
    expQ.push_back(e);
    host_u.rd(a, d);
  endtask
  task automatic settle();
    @(posedge core_clk);
    #1;
  endtask
  task automatic final_report();
    if (errors == 0 && numChecks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Empty queue gives an impossible expectation, so a stray read fails
  always @(posedge core_clk) begin
    if (regRdValid === 1'b1)
      check(regRdData, expQ.size() ? expQ.pop_front() : 11'h7ff);
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    errors++;
    final_report();
  end
  initial begin
    logic [7:0] dm[4], vd[4], tv;
    repeat (8) settle();
    rst_b = 1'b1;
    repeat (3) settle();
    host_u.wr(8'h2d, 8'h07);
    rd(8'h2d, 8'h00);
    for (int i = 0; i < 16; i++) begin
      seed = xs(seed);
      dm[i%4] = {seed[7], i[3], seed[5:3], i[2:0]};
      vd[i%4] = seed[15:8];
      host_u.wr(8'hff, {6'h01, i[1:0]});
      host_u.wr(8'h15, dm[i%4]);
      host_u.wr(8'h2d, vd[i%4]);
      settle();
      check(demTenthsDb[i%4], tenths[i[3]][i[2:0]]);
      check(vodMv[i%4], 11'd600 + 11'd100 * vd[i%4][2:0]);
    end
    for (int c = 0; c < 4; c++) begin
      host_u.wr(8'hff, {6'h01, c[1:0]});
      rd(8'h15, dm[c]);
      check(demCode[c], dm[c][2:0]);
    end
    host_u.wr(8'hff, 8'h06);
    host_u.wr(8'h39, 8'h13);
    settle();
    check(adaptStartIdx[2], 11'h000);
    expQ.push_back(8'h00);
    host_u.rmw(8'h2f, 8'h08, 8'h08);
    settle();
    check(adaptStartIdx[2], 11'h013);
    expQ.push_back(8'h08);
    host_u.rmw(8'h2f, 8'h08, 8'h00);
    settle();
    check(adaptStartIdx[2], 11'h000);
    host_u.wr(8'h00, 8'h04);
    settle();
    check(demTenthsDb[2], 11'h000);
    rd(8'h15, 8'h00);
    rd(8'h10, 8'h00);
    for (int k = 0; k < 8; k++) begin
      seed = xs(seed);
      adaptIdx = seed[19:0];
      settle();
      check(adaptBoost[2], rtc_pkg::BOOST_TBL_RST[adaptIdx[2]*8 +: 8]);
      check(adaptBoost[0], rtc_pkg::BOOST_TBL_RST[adaptIdx[0]*8 +: 8]);
    end
    // Table override on one channel; bit 0 set so it differs from default
    seed = xs(seed);
    tv = {seed[7:1], 1'b1};
    host_u.wr(8'hff, 8'h05);
    host_u.wr(8'h45, tv);
    rd(8'h45, tv);
    adaptIdx[1] = 5'h05;
    settle();
    check(adaptBoost[1], tv);
    check(adaptBoost[0], rtc_pkg::BOOST_TBL_RST[adaptIdx[0]*8 +: 8]);
    host_u.wr(8'hff, 8'h0c);
    host_u.wr(8'h2d, tv);
    settle();
    for (int c = 0; c < 4; c++)
      check(vodMv[c], 11'd600 + 11'd100 * tv[2:0]);
    repeat (2) settle();
    check(11'(expQ.size()), 11'h000);
    final_report();
  end
endmodule
`default_nettype wire
